// ==== rtl/mtc_defines.svh ====
`ifndef MTC_DEFINES_SVH
`define MTC_DEFINES_SVH

// Channel count and group size
`define MTC_NCH          12
`define MTC_GRP          6

// Register index within a channel window (byte address = ch*32 + idx*4)
`define MTC_REG_CTRL     3'h0
`define MTC_REG_STAT     3'h1
`define MTC_REG_CNT      3'h2
`define MTC_REG_GRA      3'h3
`define MTC_REG_GRB      3'h4
`define MTC_REG_GRC      3'h5
`define MTC_REG_GRD      3'h6

// Global window at channel slot 12 (byte 0x180)
`define MTC_GLOBAL_CH    4'hC
`define MTC_GLB_START    3'h0
`define MTC_GLB_SYNC     3'h1

// Control field positions
`define MTC_CTL_PSC_LSB  0
`define MTC_CTL_CLR_LSB  3
`define MTC_CTL_IOA_LSB  6
`define MTC_CTL_BUFA     14
`define MTC_CTL_BUFB     15
`define MTC_CTL_PHASE    16

// Status bits
`define MTC_ST_OVF       0
`define MTC_ST_UNF       1

// Reset values
`define MTC_CTRL_RST     17'h00000
`define MTC_CNT_RST      16'h0000
`define MTC_GR_RST       16'hFFFF
`define MTC_FLAG_RST     4'h0
`define MTC_CHV_RST      12'h000
`define MTC_PRE_RST      6'h00

// Counter limits
`define MTC_CNT_MAX      16'hFFFF
`define MTC_CNT_MIN      16'h0000

`endif

// ==== rtl/mtc_pkg.sv ====
`default_nettype none
package mtc_pkg;
  typedef enum logic [3:0] {
    MTC_IO_OFF      = 4'h0,
    MTC_IO_LOW      = 4'h1,
    MTC_IO_HIGH     = 4'h2,
    MTC_IO_TOGGLE   = 4'h3,
    MTC_IO_CAP_RISE = 4'h8,
    MTC_IO_CAP_FALL = 4'h9,
    MTC_IO_CAP_BOTH = 4'hA,
    MTC_IO_CAP_INT  = 4'hB
  } mtc_io_mode_t;

  typedef enum logic [2:0] {
    MTC_CLR_NONE = 3'h0,
    MTC_CLR_A    = 3'h1,
    MTC_CLR_B    = 3'h2,
    MTC_CLR_SYNC = 3'h3
  } mtc_clr_sel_t;

  typedef enum logic [2:0] {
    MTC_PSC_DIV1    = 3'h0,
    MTC_PSC_DIV4    = 3'h1,
    MTC_PSC_DIV16   = 3'h2,
    MTC_PSC_DIV64   = 3'h3,
    MTC_PSC_CASCADE = 3'h7
  } mtc_psc_sel_t;

  typedef logic [15:0] mtc_word_t;
endpackage
`default_nettype wire

// ==== rtl/mtc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mtc_defines.svh"

module mtc_timer
  import mtc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [8:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [11:0] timer_io_pin_first_in,
  output var  logic [11:0] timer_io_pin_first_out,
  output var  logic [11:0] timer_io_pin_first_oe,
  input  wire logic [11:0] timer_io_pin_second_in,
  output var  logic [11:0] timer_io_pin_second_out,
  output var  logic [11:0] timer_io_pin_second_oe,
  input  wire logic [11:0] count_up_in,
  input  wire logic [11:0] count_down_in
);

  function automatic logic mtc_pre_tick(input logic [2:0] s, input logic [5:0] p);
    case (s)
      MTC_PSC_DIV1:  mtc_pre_tick = 1'b1;
      MTC_PSC_DIV4:  mtc_pre_tick = &p[1:0];
      MTC_PSC_DIV16: mtc_pre_tick = &p[3:0];
      MTC_PSC_DIV64: mtc_pre_tick = &p;
      default:       mtc_pre_tick = 1'b0;
    endcase
  endfunction

  logic [5:0]  pre;
  logic [11:0] start;
  logic [11:0] sync_on;

  wire  [3:0]  a_ch  = paddr[8:5];
  wire  [2:0]  a_idx = paddr[4:2];
  wire         acc   = psel & penable & ~pready;
  wire         apb_wr = psel & penable & pwrite & pready;
  wire         glob  = (a_ch == `MTC_GLOBAL_CH);
  wire         ch_ok = (a_ch < 4'hC);

  wire [11:0]  clk_in_v;
  wire [11:0]  div1_v;
  wire [11:0]  match_a_v;
  wire [11:0]  ovf_v;
  wire [11:0]  unf_v;
  wire [11:0]  clr_ev;
  wire [11:0]  cnt_wr_v;
  wire [11:0]  map_v;
  wire [31:0]  ch_rd [12];
  wire [11:0]  pin_a_out;
  wire [11:0]  pin_b_out;
  wire [11:0]  pin_a_oe;
  wire [11:0]  pin_b_oe;

  wire         map_ok  = glob ? (a_idx <= `MTC_GLB_SYNC) : (ch_ok & map_v[a_ch]);
  wire [31:0]  glb_rd  = (a_idx == `MTC_GLB_START) ? {20'h00000, start} : {20'h00000, sync_on};
  wire [31:0]  rd_data = ~map_ok ? 32'h00000000 : glob ? glb_rd : ch_rd[a_ch];
  wire         wr_start = apb_wr & glob & (a_idx == `MTC_GLB_START);
  wire         wr_sync  = apb_wr & glob & (a_idx == `MTC_GLB_SYNC);

  always_ff @(posedge clk) begin
    if (rst) begin
      pre     <= `MTC_PRE_RST;
      start   <= `MTC_CHV_RST;
      sync_on <= `MTC_CHV_RST;
    end else begin
      pre <= pre + 6'h01;
      if (wr_start) begin
        start <= pwdata[11:0];
      end
      if (wr_sync) begin
        sync_on <= pwdata[11:0];
      end
    end
  end

  // One wait state; read data and error set with pready
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~map_ok;
      if (acc) begin
        prdata <= rd_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timer_io_pin_first_out  <= `MTC_CHV_RST;
      timer_io_pin_second_out <= `MTC_CHV_RST;
      timer_io_pin_first_oe   <= `MTC_CHV_RST;
      timer_io_pin_second_oe  <= `MTC_CHV_RST;
    end else begin
      timer_io_pin_first_out  <= pin_a_out;
      timer_io_pin_second_out <= pin_b_out;
      timer_io_pin_first_oe   <= pin_a_oe;
      timer_io_pin_second_oe  <= pin_b_oe;
    end
  end

  genvar c;
  genvar r;
  generate
    for (c = 0; c < `MTC_NCH; c++) begin : g_ch
      localparam int   LO    = (c % 3 == 1) ? c + 1 : c;
      localparam int   PT    = (c % 3 == 0) ? c + 1 : ((c % 3 == 1) ? c - 1 : c);
      localparam bit   BUF   = (c % 3 == 0);
      localparam bit   ISRC  = (c % 3 != 2);
      localparam bit   UPPER = (c % 3 == 1);
      localparam bit   PHOK  = (c % 3 != 0);
      localparam int   G0    = (c < `MTC_GRP) ? 0 : `MTC_GRP;
      localparam logic [5:0] SELF = 6'(1 << (c - G0));

      logic [16:0] ctrl;
      mtc_word_t   cnt;
      mtc_word_t   gr [4];
      logic [3:0]  flag;
      logic [1:0]  prev;
      logic [1:0]  pout;

      mtc_word_t   next_cnt;
      mtc_word_t   next_gr [4];
      logic [1:0]  next_pout;
      wire  [1:0]  ev;
      wire  [1:0]  cap;
      wire  [1:0]  mt;
      wire  [1:0]  oe;
      wire  [1:0]  pin_in = {timer_io_pin_second_in[c], timer_io_pin_first_in[c]};

      wire         ch_sel  = apb_wr & (a_ch == 4'(c));
      wire         wr_ctrl = ch_sel & (a_idx == `MTC_REG_CTRL);
      wire         wr_stat = ch_sel & (a_idx == `MTC_REG_STAT);
      wire  [2:0]  psc     = ctrl[`MTC_CTL_PSC_LSB +: 3];
      wire  [2:0]  clrsel  = ctrl[`MTC_CTL_CLR_LSB +: 3];
      wire  [1:0]  bufen   = {ctrl[`MTC_CTL_BUFB], ctrl[`MTC_CTL_BUFA]} & {2{BUF}};
      wire         phase   = ctrl[`MTC_CTL_PHASE] & PHOK;
      wire         casc    = UPPER & (psc == MTC_PSC_CASCADE) & ~phase;
      wire         raw     = mtc_pre_tick(psc, pre);
      wire         inc     = count_up_in[c] & ~count_down_in[c];
      wire         dec     = count_down_in[c] & ~count_up_in[c];
      wire         up      = start[c] & (phase ? inc : casc ? ovf_v[LO] : raw);
      wire         dn      = start[c] & (phase ? dec : casc & unf_v[LO]);
      wire         tick    = up | dn;
      wire         own_clr = ((clrsel == MTC_CLR_A) & ev[0]) |
                             ((clrsel == MTC_CLR_B) & ev[1]);
      wire         sync_clr = (clrsel == MTC_CLR_SYNC) & sync_on[c] &
                              (|(clr_ev[G0 +: 6] & ~SELF));
      wire         clear   = own_clr | sync_clr;
      wire         preset  = sync_on[c] & (|(cnt_wr_v[G0 +: 6] & sync_on[G0 +: 6]));
      wire         load    = cnt_wr_v[c] | preset;
      wire         ovf     = up & (cnt == `MTC_CNT_MAX) & ~own_clr & ~load;
      wire         unf     = dn & (cnt == `MTC_CNT_MIN) & ~own_clr & ~load;
      wire  [3:0]  fset    = {ev[1], ev[0], unf, ovf};
      wire  [3:0]  fclr    = wr_stat ? pwdata[3:0] : 4'h0;

      assign clk_in_v[c]  = raw;
      assign div1_v[c]    = (psc == MTC_PSC_DIV1);
      assign match_a_v[c] = mt[0];
      assign ovf_v[c]     = ovf;
      assign unf_v[c]     = unf;
      assign clr_ev[c]    = own_clr & sync_on[c];
      assign cnt_wr_v[c]  = ch_sel & (a_idx == `MTC_REG_CNT);
      assign map_v[c]     = (a_idx <= `MTC_REG_GRB) | (BUF & (a_idx <= `MTC_REG_GRD));
      assign pin_a_out[c] = pout[0];
      assign pin_b_out[c] = pout[1];
      assign pin_a_oe[c]  = oe[0];
      assign pin_b_oe[c]  = oe[1];

      assign next_cnt = load  ? pwdata[15:0] :
                        clear ? `MTC_CNT_MIN :
                        up    ? cnt + 16'h0001 :
                        dn    ? cnt - 16'h0001 : cnt;

      for (r = 0; r < 2; r++) begin : g_reg
        wire [3:0] md     = ctrl[`MTC_CTL_IOA_LSB + 4 * r +: 4];
        wire       rise   = pin_in[r] & ~prev[r];
        wire       fall   = ~pin_in[r] & prev[r];
        wire       int_src = (r == 0) ? (clk_in_v[PT] & ~(BUF & div1_v[PT])) : match_a_v[PT];
        wire       trig   = ((md == MTC_IO_CAP_RISE) & rise) |
                            ((md == MTC_IO_CAP_FALL) & fall) |
                            ((md == MTC_IO_CAP_BOTH) & (rise | fall)) |
                            ((md == MTC_IO_CAP_INT) & ISRC & int_src);
        wire       wr_gr  = ch_sel & (a_idx == 3'(`MTC_REG_GRA + r));
        wire       wr_buf = ch_sel & BUF & (a_idx == 3'(`MTC_REG_GRC + r));

        assign cap[r] = md[3] & trig;
        assign mt[r]  = ~md[3] & tick & (cnt == gr[r]);
        assign ev[r]  = cap[r] | mt[r];
        assign oe[r]  = (md == MTC_IO_LOW) | (md == MTC_IO_HIGH) | (md == MTC_IO_TOGGLE);

        // Capture, then buffer reload, then software write
        assign next_gr[r] = cap[r] ? cnt :
                            (mt[r] & bufen[r]) ? gr[r + 2] :
                            wr_gr ? pwdata[15:0] : gr[r];
        assign next_gr[r + 2] = (cap[r] & bufen[r]) ? gr[r] :
                                wr_buf ? pwdata[15:0] : gr[r + 2];

        // Same-level request keeps the pin as it is
        assign next_pout[r] = ~mt[r] ? pout[r] :
                              (md == MTC_IO_LOW)    ? 1'b0 :
                              (md == MTC_IO_HIGH)   ? 1'b1 :
                              (md == MTC_IO_TOGGLE) ? ~pout[r] : pout[r];
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          ctrl <= `MTC_CTRL_RST;
          cnt  <= `MTC_CNT_RST;
          flag <= `MTC_FLAG_RST;
          prev <= 2'h0;
          pout <= 2'h0;
          for (int i = 0; i < 4; i++) begin
            gr[i] <= `MTC_GR_RST;
          end
        end else begin
          if (wr_ctrl) begin
            ctrl <= pwdata[16:0];
          end
          cnt  <= next_cnt;
          flag <= (flag & ~fclr) | fset;
          prev <= pin_in;
          pout <= next_pout;
          for (int i = 0; i < 4; i++) begin
            gr[i] <= next_gr[i];
          end
        end
      end

      assign ch_rd[c] = (a_idx == `MTC_REG_CTRL) ? {15'h0000, ctrl} :
                        (a_idx == `MTC_REG_STAT) ? {28'h0000000, flag} :
                        (a_idx == `MTC_REG_CNT)  ? {16'h0000, cnt} :
                        (a_idx == `MTC_REG_GRA)  ? {16'h0000, gr[0]} :
                        (a_idx == `MTC_REG_GRB)  ? {16'h0000, gr[1]} :
                        (a_idx == `MTC_REG_GRC)  ? {16'h0000, gr[2]} :
                        (a_idx == `MTC_REG_GRD)  ? {16'h0000, gr[3]} : 32'h00000000;
    end
  endgenerate

endmodule

`default_nettype wire

// ==== test/mtc_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
module mtc_pins (
  input  wire logic        clk,
  input  wire logic [11:0] a_out,
  input  wire logic [11:0] a_oe,
  output var  logic [11:0] a_in,
  input  wire logic [11:0] b_out,
  input  wire logic [11:0] b_oe,
  output var  logic [11:0] b_in
);
  logic [11:0] ext_a = 12'h000;
  logic [11:0] ext_b = 12'h000;
  // Driven pins read back their own level
  assign a_in = (a_oe & a_out) | (~a_oe & ext_a);
  assign b_in = (b_oe & b_out) | (~b_oe & ext_b);
  task automatic set_b(input int ch, input logic v);
    @(posedge clk);
    ext_b[ch] <= v;
  endtask
  task automatic set_a(input int ch, input logic v);
    @(posedge clk);
    ext_a[ch] <= v;
  endtask
endmodule
`default_nettype wire

// ==== test/mtc_timer_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module mtc_timer_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [8:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] timer_io_pin_first_out,
  input wire logic [11:0] timer_io_pin_first_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // First access cycle of a transfer
  wire acc1 = psel && penable && !pready;
  property p_rdy_one; pready |=> !pready; endproperty
  a_rdy_one: assert property (p_rdy_one) else $error("pready longer than one cycle");
  property p_rdy_lat; acc1 |=> pready; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("pready late");
  property p_rdy_acc; pready |-> psel && penable; endproperty
  a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
  property p_err_rdy; pslverr |-> pready; endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_err_slot; acc1 && paddr[8:5] > 4'hC |=> pslverr; endproperty
  a_err_slot: assert property (p_err_slot) else $error("unmapped slot accepted");
  property p_err_ix7; acc1 && paddr[8:5] < 4'hC && paddr[4:2] == 3'h7 |=> pslverr; endproperty
  a_err_ix7: assert property (p_err_ix7) else $error("unmapped index accepted");
  property p_ok_glb; acc1 && paddr[8:5] == 4'hC && paddr[4:2] < 3'h2 |=> !pslverr; endproperty
  a_ok_glb: assert property (p_ok_glb) else $error("global register refused");
  property p_rst_idle;
    disable iff (1'b0) rst |=> !pready && !pslverr && timer_io_pin_first_oe == 12'h000;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");
  property p_oe_wr;
    $changed(timer_io_pin_first_oe) |-> $past(pwrite && pready) || $past(pwrite && pready, 2);
  endproperty
  a_oe_wr: assert property (p_oe_wr) else $error("pin enable moved without write");
  property p_out_drv;
    $changed(timer_io_pin_first_out) |-> timer_io_pin_first_oe != 12'h000;
  endproperty
  a_out_drv: assert property (p_out_drv) else $error("pin level moved undriven");
endmodule
bind mtc_timer mtc_timer_asserts u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .timer_io_pin_first_out(timer_io_pin_first_out),
  .timer_io_pin_first_oe(timer_io_pin_first_oe));
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [8:0]  paddr = 9'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] a_in;
  logic [11:0] a_out;
  logic [11:0] a_oe;
  logic [11:0] b_in;
  logic [11:0] b_out;
  logic [11:0] b_oe;
  logic [11:0] cup = 12'h000;
  logic [11:0] cdn = 12'h000;
  logic [31:0] x;
  logic        o;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cyc = 0;
  mtc_timer DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_io_pin_first_in(a_in), .timer_io_pin_first_out(a_out),
    .timer_io_pin_first_oe(a_oe), .timer_io_pin_second_in(b_in),
    .timer_io_pin_second_out(b_out), .timer_io_pin_second_oe(b_oe),
    .count_up_in(cup), .count_down_in(cdn));
  mtc_pins P (.clk(clk), .a_out(a_out), .a_oe(a_oe), .a_in(a_in), .b_out(b_out), .b_oe(b_oe),
    .b_in(b_in));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [3:0] ch, input logic [2:0] ix,
                      input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ch, ix, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] ch, input logic [2:0] ix, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, ch, ix, d, r, e);
  endtask
  task automatic rd(input logic [3:0] ch, input logic [2:0] ix, input logic [31:0] v,
                    input logic [31:0] m);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, ch, ix, 32'h0, r, e);
    chk(r & m, v);
  endtask
  task automatic bad(input logic [3:0] ch, input logic [2:0] ix);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, ch, ix, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(4'h0, 3'h3, 32'hFFFF, '1);
    rd(4'h0, 3'h0, 32'h0, '1);
    bad(4'hD, 3'h0);
    bad(4'h1, 3'h7);
    bad(4'h1, 3'h5);
    $display("map test done");
    for (int m = 0; m < 3; m++) begin
      wr(4'h1, 3'h0, (32'h8 + m) << 6);
      wr(4'h1, 3'h2, 32'h100 + m);
      wr(4'h1, 3'h3, 32'h0);
      P.set_a(1, 1'b1);
      repeat (6) @(posedge clk);
      x = (m != 1) ? 32'h100 + m : 32'h0;
      rd(4'h1, 3'h3, x, '1);
      wr(4'h1, 3'h2, 32'h200 + m);
      P.set_a(1, 1'b0);
      repeat (6) @(posedge clk);
      rd(4'h1, 3'h3, (m != 0) ? 32'h200 + m : x, '1);
    end
    wr(4'h0, 3'h0, 32'h4280);
    wr(4'h0, 3'h3, 32'h1111);
    wr(4'h0, 3'h5, 32'h0);
    wr(4'h0, 3'h2, 32'h2222);
    P.set_a(0, 1'b1);
    repeat (6) @(posedge clk);
    rd(4'h0, 3'h3, 32'h2222, '1);
    rd(4'h0, 3'h5, 32'h1111, '1);
    $display("capture test done");
    wr(4'hC, 3'h1, 32'h45);
    wr(4'h0, 3'h2, 32'h500);
    rd(4'h2, 3'h2, 32'h500, '1);
    rd(4'h6, 3'h2, 32'h0, '1);
    wr(4'hC, 3'h1, 32'h0);
    $display("sync test done");
    wr(4'h4, 3'h0, 32'hC8);
    wr(4'h4, 3'h3, 32'h2);
    wr(4'hC, 3'h0, 32'h10);
    repeat (9) @(posedge clk);
    o = a_out[4];
    repeat (3) @(posedge clk);
    chk({31'h0, a_out[4]}, {31'h0, ~o});
    rd(4'h4, 3'h1, 32'h4, 32'h4);
    $display("toggle test done");
    wr(4'h5, 3'h2, 32'hFFFD);
    wr(4'h2, 3'h2, 32'hFFFE);
    wr(4'h1, 3'h2, 32'h5);
    wr(4'h1, 3'h0, 32'h7);
    wr(4'h3, 3'h0, 32'h40C8);
    wr(4'h3, 3'h3, 32'h4);
    wr(4'h3, 3'h5, 32'h9);
    wr(4'hC, 3'h0, 32'h3E);
    repeat (20) @(posedge clk);
    rd(4'h5, 3'h1, 32'h1, 32'h1);
    rd(4'h1, 3'h2, 32'h6, '1);
    rd(4'h3, 3'h3, 32'h9, '1);
    $display("count test done");
    wr(4'h6, 3'h0, 32'h850);
    wr(4'h6, 3'h3, 32'h1);
    wr(4'h6, 3'h4, 32'h3);
    wr(4'hC, 3'h0, 32'h7E);
    repeat (12) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      chk({31'h0, b_out[6]}, 32'h1);
      chk({31'h0, a_out[6]}, 32'h0);
      chk({30'h0, b_oe[6], a_oe[6]}, 32'h3);
      @(posedge clk);
    end
    $display("level test done");
    wr(4'h7, 3'h0, 32'h2010);
    wr(4'h7, 3'h2, 32'h1234);
    P.set_b(7, 1'b1);
    repeat (3) @(posedge clk);
    rd(4'h7, 3'h4, 32'h1234, '1);
    rd(4'h7, 3'h2, 32'h0, '1);
    rd(4'h7, 3'h1, 32'h8, 32'h8);
    wr(4'h9, 3'h0, 32'h208);
    wr(4'hA, 3'h0, 32'h18);
    wr(4'hC, 3'h1, 32'h600);
    wr(4'h9, 3'h2, 32'h77);
    rd(4'hA, 3'h2, 32'h77, '1);
    P.set_a(9, 1'b1);
    repeat (3) @(posedge clk);
    rd(4'h9, 3'h3, 32'h77, '1);
    rd(4'hA, 3'h2, 32'h0, '1);
    $display("clear test done");
    wr(4'hC, 3'h1, 32'h0);
    wr(4'hA, 3'h0, 32'h7);
    wr(4'hB, 3'h0, 32'h10000);
    wr(4'h7, 3'h0, 32'h10007);
    wr(4'hC, 3'h0, 32'hCFE);
    cup[7] <= 1'b1;
    cdn[11] <= 1'b1;
    @(posedge clk);
    cup[7] <= 1'b0;
    cdn[11] <= 1'b0;
    repeat (2) @(posedge clk);
    rd(4'hB, 3'h2, 32'hFFFF, '1);
    rd(4'hB, 3'h1, 32'h2, 32'h2);
    rd(4'hA, 3'h2, 32'hFFFF, '1);
    rd(4'h7, 3'h2, 32'h1, '1);
    $display("phase test done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
